// file: core/pac_pkg.sv
package pac_pkg;

  // byte offsets of the apb register words
  localparam logic [7:0] PAC_OFF_CTRL  = 8'h00;
  localparam logic [7:0] PAC_OFF_COUNT = 8'h04;
  localparam logic [7:0] PAC_OFF_MASK  = 8'h08;
  localparam logic [7:0] PAC_OFF_FLAG  = 8'h0C;

  // control register fields
  localparam int PAC_CTRL_EN_BIT   = 6;
  localparam int PAC_CTRL_MODE_BIT = 5;
  localparam int PAC_CTRL_EDGE_BIT = 4;
  localparam int PAC_CTRL_SEL_BIT  = 2;

  // mask and flag register fields
  localparam int PAC_MASK_OVF_BIT  = 5;
  localparam int PAC_MASK_EDGE_BIT = 4;
  localparam int PAC_FLAG_OVF_BIT  = 5;
  localparam int PAC_FLAG_EDGE_BIT = 4;

  // reset value of single-bit state; compare five enable resets to its inverse
  localparam logic PAC_BIT_RST = 1'b0;

  // counter and tick divider sizes
  localparam int         PAC_CNT_W   = 8;
  localparam logic [7:0] PAC_CNT_MAX = 8'hFF;
  localparam int         PAC_TICK_DIV = 64;
  localparam int         PAC_TICK_W   = $clog2(PAC_TICK_DIV);
  localparam logic [PAC_TICK_W-1:0] PAC_TICK_LAST = PAC_TICK_W'(PAC_TICK_DIV - 1);
  localparam logic [PAC_TICK_W-1:0] PAC_TICK_RST  = '0;

  typedef logic [PAC_CNT_W-1:0] pac_byte_t;

endpackage

// file: core/pac_link_if.sv
`timescale 1ns/1ps
interface pac_link_if;
  logic              tick;
  logic              pin_rise;
  logic              pin_fall;
  logic              pin_level;
  logic              cnt_inc;
  logic              cnt_wr;
  pac_pkg::pac_byte_t cnt_wdata;
  pac_pkg::pac_byte_t cnt_q;
  logic              cnt_wrap;

  modport gen (output tick, output pin_rise, output pin_fall, output pin_level);
  modport ctr (input cnt_inc, input cnt_wr, input cnt_wdata, output cnt_q, output cnt_wrap);
  modport top (input tick, input pin_rise, input pin_fall, input pin_level,
               output cnt_inc, output cnt_wr, output cnt_wdata, input cnt_q, input cnt_wrap);
endinterface

// file: core/pac_tick_gen.sv
`timescale 1ns/1ps
module pac_tick_gen (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic accum_input_pin,
  pac_link_if.gen   link
);

  logic [pac_pkg::PAC_TICK_W-1:0] div_q;
  logic                           pin_prev_q;
  logic                           prev_ok_q;

  // free-running divide-by-64, never stopped by the enable bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_q <= pac_pkg::PAC_TICK_RST;
    end else if (clk_en) begin
      div_q <= div_q + 1'b1;
    end
  end

  // previous pin level, trusted only after one sample
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_prev_q <= pac_pkg::PAC_BIT_RST;
      prev_ok_q  <= pac_pkg::PAC_BIT_RST;
    end else if (clk_en) begin
      pin_prev_q <= accum_input_pin;
      prev_ok_q  <= 1'b1;
    end
  end

  // tick and edge strobes
  assign link.tick      = clk_en & (div_q == pac_pkg::PAC_TICK_LAST);
  assign link.pin_rise  = clk_en & prev_ok_q & accum_input_pin & ~pin_prev_q;
  assign link.pin_fall  = clk_en & prev_ok_q & ~accum_input_pin & pin_prev_q;
  assign link.pin_level = accum_input_pin;

endmodule

// file: core/pac_counter.sv
`timescale 1ns/1ps
module pac_counter (
  input  wire logic clock,
  input  wire logic clk_en,
  pac_link_if.ctr   link
);

  pac_pkg::pac_byte_t cnt_q;

  // count holds no reset; a write wins over an increment
  always_ff @(posedge clock) begin
    if (clk_en) begin
      if (link.cnt_wr) begin
        cnt_q <= link.cnt_wdata;
      end else if (link.cnt_inc) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // wrap from FF to 00 on a kept increment
  assign link.cnt_wrap = link.cnt_inc & ~link.cnt_wr & (cnt_q == pac_pkg::PAC_CNT_MAX);
  assign link.cnt_q    = cnt_q;

endmodule

// file: core/pac_accumulator.sv
`timescale 1ns/1ps
module pac_accumulator (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        accum_input_pin,
  output logic             overflow_irq_req,
  output logic             edge_irq_req,
  output logic             compare_five_enable,
  output logic             capture_four_enable
);

  pac_link_if link ();

  // control and mask state
  logic en_q;
  logic en_d;
  logic mode_q;
  logic mode_d;
  logic edge_sel_q;
  logic edge_sel_d;
  logic sel_q;
  logic sel_d;
  logic ovf_ie_q;
  logic ovf_ie_d;
  logic edge_ie_q;
  logic edge_ie_d;

  // flag state
  logic ovf_flag_q;
  logic ovf_flag_d;
  logic edge_flag_q;
  logic edge_flag_d;

  // bus state
  logic        ready_q;
  logic        ready_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // registered output state
  logic ovf_irq_q;
  logic ovf_irq_d;
  logic edge_irq_q;
  logic edge_irq_d;
  logic cmp5_q;
  logic cmp5_d;
  logic cap4_q;
  logic cap4_d;

  // bus decode wires
  logic setup_phase;
  logic access_phase;
  logic access_done;
  logic wr_done;
  logic hit_ctrl;
  logic hit_count;
  logic hit_mask;
  logic hit_flag;
  logic addr_hit;

  // write strobes
  logic wr_ctrl;
  logic wr_count;
  logic wr_mask;
  logic wr_flag;
  logic clr_ovf;
  logic clr_edge;

  // counting wires
  logic gate_open;
  logic sel_edge;
  logic event_inc;
  logic gated_inc;
  logic set_edge;
  logic set_ovf;

  // read data
  pac_pkg::pac_byte_t ctrl_rd;
  pac_pkg::pac_byte_t mask_rd;
  pac_pkg::pac_byte_t flag_rd;
  pac_pkg::pac_byte_t rd_byte;

  // tick divider and pin edge detector
  pac_tick_gen u_tick_gen (
    .clock           (clock),
    .rst             (rst),
    .clk_en          (clk_en),
    .accum_input_pin (accum_input_pin),
    .link            (link)
  );

  // 8-bit count register
  pac_counter u_counter (
    .clock  (clock),
    .clk_en (clk_en),
    .link   (link)
  );

  // apb phases
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign access_done  = access_phase & pready;
  assign wr_done      = access_done & pwrite;

  // address decode, whole byte address compared
  assign hit_ctrl  = (paddr == pac_pkg::PAC_OFF_CTRL);
  assign hit_count = (paddr == pac_pkg::PAC_OFF_COUNT);
  assign hit_mask  = (paddr == pac_pkg::PAC_OFF_MASK);
  assign hit_flag  = (paddr == pac_pkg::PAC_OFF_FLAG);
  assign addr_hit  = hit_ctrl | hit_count | hit_mask | hit_flag;

  // answer once read data has been captured; frozen while clk_en low
  assign pready  = clk_en & ready_q & access_phase;
  assign pslverr = pready & ~addr_hit;
  assign prdata  = prdata_q;

  // ready follows one enabled edge after the request appears
  assign ready_d = psel & ~access_done;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ready_q <= pac_pkg::PAC_BIT_RST;
    end else if (clk_en) begin
      ready_q <= ready_d;
    end
  end

  // write strobes, effective only at the completing edge
  assign wr_ctrl  = wr_done & hit_ctrl;
  assign wr_count = wr_done & hit_count;
  assign wr_mask  = wr_done & hit_mask;
  assign wr_flag  = wr_done & hit_flag;

  // control register next values
  assign en_d       = wr_ctrl ? pwdata[pac_pkg::PAC_CTRL_EN_BIT]   : en_q;
  assign mode_d     = wr_ctrl ? pwdata[pac_pkg::PAC_CTRL_MODE_BIT] : mode_q;
  assign edge_sel_d = wr_ctrl ? pwdata[pac_pkg::PAC_CTRL_EDGE_BIT] : edge_sel_q;
  assign sel_d      = wr_ctrl ? pwdata[pac_pkg::PAC_CTRL_SEL_BIT]  : sel_q;

  // accumulator enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_q <= pac_pkg::PAC_BIT_RST;
    end else if (clk_en) begin
      en_q <= en_d;
    end
  end

  // mode: event or gated
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= pac_pkg::PAC_BIT_RST;
    end else if (clk_en) begin
      mode_q <= mode_d;
    end
  end

  // edge or gate polarity
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      edge_sel_q <= pac_pkg::PAC_BIT_RST;
    end else if (clk_en) begin
      edge_sel_q <= edge_sel_d;
    end
  end

  // capture four / compare five select
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_q <= pac_pkg::PAC_BIT_RST;
    end else if (clk_en) begin
      sel_q <= sel_d;
    end
  end

  // interrupt enables next values
  assign ovf_ie_d  = wr_mask ? pwdata[pac_pkg::PAC_MASK_OVF_BIT]  : ovf_ie_q;
  assign edge_ie_d = wr_mask ? pwdata[pac_pkg::PAC_MASK_EDGE_BIT] : edge_ie_q;

  // interrupt enable bits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovf_ie_q  <= pac_pkg::PAC_BIT_RST;
      edge_ie_q <= pac_pkg::PAC_BIT_RST;
    end else if (clk_en) begin
      ovf_ie_q  <= ovf_ie_d;
      edge_ie_q <= edge_ie_d;
    end
  end

  // gate open when pin is away from the blocking level
  assign gate_open = link.pin_level ^ edge_sel_q;

  // selected edge: rising when edge bit set, else falling
  assign sel_edge = edge_sel_q ? link.pin_rise : link.pin_fall;

  // event mode increments on the selected edge
  assign event_inc = ~mode_q & sel_edge;

  // gated mode increments on the tick while gate open
  assign gated_inc = mode_q & link.tick & gate_open;

  // nothing counts while disabled
  assign link.cnt_inc   = en_q & (event_inc | gated_inc);
  assign link.cnt_wr    = wr_count;
  assign link.cnt_wdata = pwdata[pac_pkg::PAC_CNT_W-1:0];

  // flag set terms
  assign set_ovf  = link.cnt_wrap;
  assign set_edge = en_q & sel_edge;

  // write-one-to-clear; zeros leave flags alone
  assign clr_ovf  = wr_flag & pwdata[pac_pkg::PAC_FLAG_OVF_BIT];
  assign clr_edge = wr_flag & pwdata[pac_pkg::PAC_FLAG_EDGE_BIT];

  // set wins over a clear in the same cycle
  assign ovf_flag_d  = set_ovf | (ovf_flag_q & ~clr_ovf);
  assign edge_flag_d = set_edge | (edge_flag_q & ~clr_edge);

  // overflow flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovf_flag_q <= pac_pkg::PAC_BIT_RST;
    end else if (clk_en) begin
      ovf_flag_q <= ovf_flag_d;
    end
  end

  // input edge flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      edge_flag_q <= pac_pkg::PAC_BIT_RST;
    end else if (clk_en) begin
      edge_flag_q <= edge_flag_d;
    end
  end

  // control read image, unimplemented bits zero
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[pac_pkg::PAC_CTRL_EN_BIT]   = en_q;
    ctrl_rd[pac_pkg::PAC_CTRL_MODE_BIT] = mode_q;
    ctrl_rd[pac_pkg::PAC_CTRL_EDGE_BIT] = edge_sel_q;
    ctrl_rd[pac_pkg::PAC_CTRL_SEL_BIT]  = sel_q;
  end

  // mask read image
  always_comb begin
    mask_rd = '0;
    mask_rd[pac_pkg::PAC_MASK_OVF_BIT]  = ovf_ie_q;
    mask_rd[pac_pkg::PAC_MASK_EDGE_BIT] = edge_ie_q;
  end

  // flag read image
  always_comb begin
    flag_rd = '0;
    flag_rd[pac_pkg::PAC_FLAG_OVF_BIT]  = ovf_flag_q;
    flag_rd[pac_pkg::PAC_FLAG_EDGE_BIT] = edge_flag_q;
  end

  // read select, unmapped reads as zero
  assign rd_byte = hit_ctrl  ? ctrl_rd :
                   hit_count ? link.cnt_q :
                   hit_mask  ? mask_rd :
                   hit_flag  ? flag_rd :
                   8'h00;

  // capture on an edge, so a read sees a whole count
  assign prdata_d = (psel & ~pwrite & ~ready_q) ? {24'h000000, rd_byte} : prdata_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
    end else if (clk_en) begin
      prdata_q <= prdata_d;
    end
  end

  // interrupt requests gated by enables, flags untouched
  assign ovf_irq_d  = ovf_flag_d & ovf_ie_d;
  assign edge_irq_d = edge_flag_d & edge_ie_d;

  // request flops fed from next state, so no added latency
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovf_irq_q  <= pac_pkg::PAC_BIT_RST;
      edge_irq_q <= pac_pkg::PAC_BIT_RST;
    end else if (clk_en) begin
      ovf_irq_q  <= ovf_irq_d;
      edge_irq_q <= edge_irq_d;
    end
  end

  // capture four or compare five enable
  assign cmp5_d = ~sel_d;
  assign cap4_d = sel_d;

  // select flops; compare five is on after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmp5_q <= ~pac_pkg::PAC_BIT_RST;
      cap4_q <= pac_pkg::PAC_BIT_RST;
    end else if (clk_en) begin
      cmp5_q <= cmp5_d;
      cap4_q <= cap4_d;
    end
  end

  // outputs straight from flops
  assign overflow_irq_req    = ovf_irq_q;
  assign edge_irq_req        = edge_irq_q;
  assign compare_five_enable = cmp5_q;
  assign capture_four_enable = cap4_q;

endmodule

// file: verification/pac_pin_model.sv
`timescale 1ns/1ps
module pac_pin_model (
  input  wire logic       clock,
  input  wire logic       idle_lvl,
  input  wire logic       go,
  input  wire logic [7:0] pulses,
  output logic            pin,
  output logic            busy
);
  logic [8:0] left_q;
  logic       ph_q;

  // pin starts high, no burst pending
  initial begin
    pin = 1'b1;
    busy = 1'b0;
    left_q = 9'h000;
    ph_q = 1'b0;
  end

  // burst of pulses, one toggle every two clocks, never faster
  always @(posedge clock) begin
    if (busy) begin
      ph_q <= ~ph_q;
      if (ph_q) begin
        pin <= ~pin;
        left_q <= left_q - 9'h001;
        busy <= (left_q != 9'h001);
      end
    end else if (go) begin
      busy <= 1'b1;
      left_q <= {pulses, 1'b0};
      ph_q <= 1'b0;
    end else begin
      pin <= idle_lvl;
    end
  end
endmodule

// file: verification/pac_accumulator_chk.sv
`timescale 1ns/1ps
module pac_accumulator_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        accum_input_pin,
  input wire logic        overflow_irq_req,
  input wire logic        edge_irq_req,
  input wire logic        compare_five_enable,
  input wire logic        capture_four_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // bus phases
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_wr;
    psel && penable && pready && pwrite;
  endsequence

  property p_zero_wait; s_setup ##1 (psel && penable && clk_en) |-> pready; endproperty
  property p_ready_acc; pready |-> psel && penable && clk_en; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_unmap_rd; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  property p_sel_excl; capture_four_enable != compare_five_enable; endproperty
  property p_rst_vals; $fell(rst) |-> !overflow_irq_req && !edge_irq_req && compare_five_enable; endproperty
  property p_mask_ovf; s_wr and paddr == pac_pkg::PAC_OFF_MASK && !pwdata[5] |=> !overflow_irq_req; endproperty
  property p_mask_edge; s_wr and paddr == pac_pkg::PAC_OFF_MASK && !pwdata[4] |=> !edge_irq_req; endproperty
  property p_keep_ovf;
    s_wr and paddr == pac_pkg::PAC_OFF_FLAG && !pwdata[5] && overflow_irq_req |=> overflow_irq_req;
  endproperty
  property p_clr_edge;
    s_wr and paddr == pac_pkg::PAC_OFF_FLAG && pwdata[4] && $stable(accum_input_pin) |=> !edge_irq_req;
  endproperty

  a_zero_wait: assert property (p_zero_wait) else $error("pready late");
  a_ready_acc: assert property (p_ready_acc) else $error("pready outside access");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped read not zero");
  a_sel_excl: assert property (p_sel_excl) else $error("select outputs equal");
  a_rst_vals: assert property (p_rst_vals) else $error("bad outputs after reset");
  a_mask_ovf: assert property (p_mask_ovf) else $error("overflow request not masked");
  a_mask_edge: assert property (p_mask_edge) else $error("edge request not masked");
  a_keep_ovf: assert property (p_keep_ovf) else $error("overflow lost on zero write");
  a_clr_edge: assert property (p_clr_edge) else $error("edge flag not cleared");
endmodule

bind pac_accumulator pac_accumulator_chk chk_u (
  .clock(clock), .rst(rst), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .accum_input_pin(accum_input_pin), .overflow_irq_req(overflow_irq_req), .edge_irq_req(edge_irq_req),
  .compare_five_enable(compare_five_enable), .capture_four_enable(capture_four_enable)
);

// file: verification/test_pulse_accumulator_counter.sv
`timescale 1ns/1ps
module test_pulse_accumulator_counter;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd_q;
  logic        pready, pslverr, er_q, pin, busy, ovf_irq, edge_irq, cmp5, cap4;
  logic        lvl = 1'b1;
  logic        go = 1'b0;
  logic        en = 1'b1;
  logic [7:0]  np = 8'h01;
  int          error_cnt = 0;
  int          num_checks = 0;
  logic [7:0]  g_ctl [4] = '{8'h60, 8'h60, 8'h70, 8'h70};
  logic        g_lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [31:0] g_exp [4] = '{32'h4, 32'h0, 32'h0, 32'h4};

  // 40 MHz clock
  always #12.5 clock = ~clock;

  pac_accumulator dut_u (
    .clock(clock), .rst(rst), .clk_en(en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .accum_input_pin(pin), .overflow_irq_req(ovf_irq), .edge_irq_req(edge_irq),
    .compare_five_enable(cmp5), .capture_four_enable(cap4)
  );
  pac_pin_model pin_u (.clock(clock), .idle_lvl(lvl), .go(go), .pulses(np), .pin(pin), .busy(busy));

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    rd_q = prdata;
    er_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd_q);
  endtask

  // burst of pulses from the pin model, bounded wait
  task automatic pulse(input logic [7:0] n);
    int k;
    go <= 1'b1;
    np <= n;
    @(posedge clock);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (busy !== 1'b0 && k < 100);
    if (busy !== 1'b0) begin
      error_cnt++;
      report_and_stop();
    end
    repeat (3) @(posedge clock);
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd("ctrl", pac_pkg::PAC_OFF_CTRL, 32'h0);
    rd("mask", pac_pkg::PAC_OFF_MASK, 32'h0);
    rd("flag", pac_pkg::PAC_OFF_FLAG, 32'h0);
    chk("cmp5", 32'h1, {31'h0, cmp5});
    apb(1'b1, pac_pkg::PAC_OFF_COUNT, 32'h5A);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd("count", pac_pkg::PAC_OFF_COUNT, 32'h5A);
    pulse(8'h03);
    rd("count", pac_pkg::PAC_OFF_COUNT, 32'h5A);
    rd("flag", pac_pkg::PAC_OFF_FLAG, 32'h0);
    // falling then rising edge under both edge selections
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, pac_pkg::PAC_OFF_CTRL, (e == 1) ? 32'h50 : 32'h40);
      apb(1'b1, pac_pkg::PAC_OFF_COUNT, 32'h0);
      apb(1'b1, pac_pkg::PAC_OFF_FLAG, 32'h30);
      lvl <= 1'b0;
      repeat (4) @(posedge clock);
      rd("count", pac_pkg::PAC_OFF_COUNT, (e == 1) ? 32'h0 : 32'h1);
      lvl <= 1'b1;
      repeat (4) @(posedge clock);
      rd("count", pac_pkg::PAC_OFF_COUNT, 32'h1);
      rd("flag", pac_pkg::PAC_OFF_FLAG, 32'h10);
    end
    // wrap with requests enabled, then flag clearing
    apb(1'b1, pac_pkg::PAC_OFF_MASK, 32'h30);
    apb(1'b1, pac_pkg::PAC_OFF_CTRL, 32'h44);
    // pin falls so that its increment meets the count write
    lvl <= 1'b0;
    apb(1'b1, pac_pkg::PAC_OFF_COUNT, 32'hFE);
    rd("count", pac_pkg::PAC_OFF_COUNT, 32'hFE);
    apb(1'b1, pac_pkg::PAC_OFF_FLAG, 32'h30);
    pulse(8'h03);
    chk("cap4", 32'h1, {31'h0, cap4});
    rd("count", pac_pkg::PAC_OFF_COUNT, 32'h1);
    rd("flag", pac_pkg::PAC_OFF_FLAG, 32'h30);
    chk("ovf_irq", 32'h1, {31'h0, ovf_irq});
    apb(1'b1, pac_pkg::PAC_OFF_FLAG, 32'h10);
    rd("flag", pac_pkg::PAC_OFF_FLAG, 32'h20);
    apb(1'b1, pac_pkg::PAC_OFF_FLAG, 32'h20);
    rd("flag", pac_pkg::PAC_OFF_FLAG, 32'h0);
    pulse(8'h01);
    chk("edge_irq", 32'h1, {31'h0, edge_irq});
    chk("ovf_irq", 32'h0, {31'h0, ovf_irq});
    apb(1'b1, pac_pkg::PAC_OFF_MASK, 32'h0);
    chk("edge_irq", 32'h0, {31'h0, edge_irq});
    rd("flag", pac_pkg::PAC_OFF_FLAG, 32'h10);
    // unmapped word
    apb(1'b1, 8'h10, 32'hFF);
    chk("werr", 32'h1, {31'h0, er_q});
    rd("unmapped", 8'h10, 32'h0);
    chk("rerr", 32'h1, {31'h0, er_q});
    // gated mode, 256 cycles hold exactly four ticks when open
    for (int i = 0; i < 4; i++) begin
      lvl <= g_lvl[i];
      apb(1'b1, pac_pkg::PAC_OFF_CTRL, {24'h0, g_ctl[i]});
      apb(1'b1, pac_pkg::PAC_OFF_COUNT, 32'h0);
      // first pass: clock enable low freezes divider and count
      if (i == 0) begin
        en <= 1'b0;
        repeat (128) @(posedge clock);
        en <= 1'b1;
      end
      repeat (255) @(posedge clock);
      rd("gated", pac_pkg::PAC_OFF_COUNT, g_exp[i]);
    end
    report_and_stop();
  end
endmodule
